/* File: opm_pkg.sv */
// Constants and types for the oscillator and power mode controller.
// Assumes a single 100 MHz system clock domain.
package opm_pkg;

	////////////////////////////////////////////////////////////
	// Clock rate
	localparam int          OPM_CLK_MHZ      = 100;

	// Register offsets
	localparam logic [2:0]  OPM_ADDR_IRC     = 3'h0;
	localparam logic [2:0]  OPM_ADDR_HXC     = 3'h1;
	localparam logic [2:0]  OPM_ADDR_LXC     = 3'h2;
	localparam logic [2:0]  OPM_ADDR_SCC     = 3'h3;
	localparam logic [2:0]  OPM_ADDR_STAT    = 3'h4;

	// Field positions
	localparam int          OPM_EN_BIT       = 0;
	localparam int          OPM_FLAG_BIT     = 1;
	localparam int          OPM_OPT_BIT      = 2;
	localparam int          OPM_FREQ_LSB     = 2;
	localparam int          OPM_CKS_LSB      = 5;
	localparam int          OPM_FHS_BIT      = 3;
	localparam int          OPM_FSS_BIT      = 2;
	localparam int          OPM_KEEP_HI_BIT  = 1;
	localparam int          OPM_KEEP_LO_BIT  = 0;
	localparam int          OPM_ST_PDF_BIT   = 0;
	localparam int          OPM_ST_TO_BIT    = 1;
	localparam int          OPM_ST_HALT_BIT  = 2;
	localparam int          OPM_ST_SLOW_BIT  = 3;

	// Reset values
	localparam logic [7:0]  OPM_IRC_RESET    = 8'h01;
	localparam logic [7:0]  OPM_HXC_RESET    = 8'h00;
	localparam logic [7:0]  OPM_LXC_RESET    = 8'h00;
	localparam logic [7:0]  OPM_SCC_RESET    = 8'h00;

	// Encodings
	localparam logic [2:0]  OPM_CKS_LOW      = 3'h7;
	localparam logic [1:0]  OPM_HIGH_SPEED_INTERNAL_RC_2M      = 2'h0;
	localparam logic [1:0]  OPM_HIGH_SPEED_INTERNAL_RC_4M      = 2'h1;
	localparam logic [1:0]  OPM_HIGH_SPEED_INTERNAL_RC_8M      = 2'h2;
	localparam logic [1:0]  OPM_HIGH_SPEED_INTERNAL_RC_ALIAS   = 2'h3;

	// Oscillator indices
	localparam int          OPM_HIGH_SPEED_INTERNAL_RC         = 0;
	localparam int          OPM_HXT          = 1;
	localparam int          OPM_LXT          = 2;

	// Settling times and their cycle counts (rounded up)
	localparam int          OPM_HIGH_SPEED_INTERNAL_RC_SET_NS  = 1500;
	localparam int          OPM_HXT_SET_NS   = 3000;
	localparam int          OPM_LXT_FAST_NS  = 8000;
	localparam int          OPM_LXT_SLOW_NS  = 30000;
	localparam logic [11:0] OPM_HIGH_SPEED_INTERNAL_RC_SET_CYC = 12'((OPM_HIGH_SPEED_INTERNAL_RC_SET_NS * OPM_CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OPM_HXT_SET_CYC  = 12'((OPM_HXT_SET_NS * OPM_CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OPM_LXT_FAST_CYC = 12'((OPM_LXT_FAST_NS * OPM_CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OPM_LXT_SLOW_CYC = 12'((OPM_LXT_SLOW_NS * OPM_CLK_MHZ + 999) / 1000);

	////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		opm_run,
		opm_sleep,
		opm_idle_low,
		opm_idle_both,
		opm_idle_high
	} opm_mode_e;

	typedef struct packed {
		logic       high_speed_internal_rc_en;
		logic [1:0] high_speed_internal_rc_trim;
		logic       hxt_en;
		logic       hxt_high_drive;
		logic       lxt_en;
		logic       lxt_speedup;
		logic       low_speed_internal_rc_en;
	} opm_osc_s;

	typedef struct packed {
		logic       low_speed;
		logic [2:0] div_code;
		logic       high_xtal;
		logic       low_xtal;
	} opm_clk_sel_s;

endpackage

/* File: opm_ctrl.sv */
// Oscillator enables, stable flags, system clock selection and halt modes.
// Assumes CPU events and register strobes come from logic on clk;
// oscillator settling is timed by counters on clk.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module opm_ctrl (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// Register port
	input  wire logic [2:0]            addr,
	input  wire logic [7:0]            wdata,
	input  wire logic                  wr_stb,
	input  wire logic                  rd_stb,
	output logic [7:0]                 rdata,
	// CPU core events
	input  wire logic                  halt_req,
	input  wire logic                  wake_req,
	input  wire logic                  wdt_clear_cmd,
	input  wire logic                  wdt_timeout,
	input  wire logic                  crystal_pins_on,
	// Oscillator and clock controls
	output opm_pkg::opm_osc_s          osc_ctrl,
	output opm_pkg::opm_clk_sel_s      clk_sel,
	output logic [1:0]                 high_speed_internal_rc_freq_active,
	// Power mode status
	output logic                       cpu_hold,
	output logic                       sys_clk_run,
	output logic                       wdt_clear,
	output logic                       power_down_flag,
	output logic                       timeout_flag
);
	import opm_pkg::*;

	////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic is_wr(input logic [2:0] off);
		is_wr = wr_stb && (addr == off);
	endfunction

	function automatic logic [1:0] high_speed_internal_rc_norm(input logic [1:0] f);
		high_speed_internal_rc_norm = (f == OPM_HIGH_SPEED_INTERNAL_RC_ALIAS) ? OPM_HIGH_SPEED_INTERNAL_RC_2M : f;
	endfunction

	function automatic opm_mode_e halt_decode(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00:   halt_decode = opm_sleep;
			2'b01:   halt_decode = opm_idle_low;
			2'b11:   halt_decode = opm_idle_both;
			default: halt_decode = opm_idle_high;
		endcase
	endfunction

	////////////////////////////////////////////////////////////
	// Control registers
	logic       internal_rc_enable;
	logic [1:0] internal_rc_freq_select;
	logic       high_crystal_enable;
	logic       crystal_drive_mode;
	logic       low_crystal_enable;
	logic       low_crystal_speedup;
	logic [2:0] system_clock_source_field;
	logic       high_clock_select;
	logic       low_clock_select;
	logic       halt_keep_high_osc;
	logic       halt_keep_low_osc;
	logic       stable [3];
	logic       drive_locked;
	logic       speedup_locked;

	assign drive_locked   = crystal_pins_on && high_crystal_enable;
	assign speedup_locked = (system_clock_source_field == OPM_CKS_LOW) && low_clock_select;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			internal_rc_enable      <= OPM_IRC_RESET[OPM_EN_BIT];
			internal_rc_freq_select <= OPM_IRC_RESET[OPM_FREQ_LSB +: 2];
		end else if (is_wr(OPM_ADDR_IRC)) begin
			internal_rc_enable      <= wdata[OPM_EN_BIT];
			internal_rc_freq_select <= wdata[OPM_FREQ_LSB +: 2];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			high_crystal_enable <= OPM_HXC_RESET[OPM_EN_BIT];
			crystal_drive_mode  <= OPM_HXC_RESET[OPM_OPT_BIT];
		end else if (is_wr(OPM_ADDR_HXC)) begin
			high_crystal_enable <= wdata[OPM_EN_BIT];
			if (!drive_locked) begin
				crystal_drive_mode <= wdata[OPM_OPT_BIT];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			low_crystal_enable  <= OPM_LXC_RESET[OPM_EN_BIT];
			low_crystal_speedup <= OPM_LXC_RESET[OPM_OPT_BIT];
		end else if (is_wr(OPM_ADDR_LXC)) begin
			low_crystal_enable <= wdata[OPM_EN_BIT];
			if (!speedup_locked) begin
				low_crystal_speedup <= wdata[OPM_OPT_BIT];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			system_clock_source_field <= OPM_SCC_RESET[OPM_CKS_LSB +: 3];
			high_clock_select         <= OPM_SCC_RESET[OPM_FHS_BIT];
			low_clock_select          <= OPM_SCC_RESET[OPM_FSS_BIT];
			halt_keep_high_osc        <= OPM_SCC_RESET[OPM_KEEP_HI_BIT];
			halt_keep_low_osc         <= OPM_SCC_RESET[OPM_KEEP_LO_BIT];
		end else if (is_wr(OPM_ADDR_SCC)) begin
			system_clock_source_field <= wdata[OPM_CKS_LSB +: 3];
			high_clock_select         <= wdata[OPM_FHS_BIT];
			low_clock_select          <= wdata[OPM_FSS_BIT];
			halt_keep_high_osc        <= wdata[OPM_KEEP_HI_BIT];
			halt_keep_low_osc         <= wdata[OPM_KEEP_LO_BIT];
		end
	end

	////////////////////////////////////////////////////////////
	// Halt mode sequencing
	opm_mode_e mode;
	opm_mode_e next_mode;
	logic      halt_enter;

	assign halt_enter = (mode == opm_run) && halt_req;

	always_comb begin
		next_mode = mode;
		case (mode)
			opm_run: begin
				if (halt_req) begin
					next_mode = halt_decode(halt_keep_high_osc, halt_keep_low_osc);
				end
			end
			default: begin
				if (wake_req) begin
					next_mode = opm_run;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode        <= opm_run;
			cpu_hold    <= 1'b0;
			sys_clk_run <= 1'b1;
		end else begin
			mode        <= next_mode;
			cpu_hold    <= next_mode != opm_run;
			sys_clk_run <= next_mode == opm_run;
		end
	end

	// Halt entry wins over a same-cycle power-down flag clear; a time-out set wins over halt entry
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			power_down_flag <= 1'b0;
			timeout_flag    <= 1'b0;
			wdt_clear       <= 1'b0;
		end else begin
			wdt_clear <= halt_enter;
			if (halt_enter) begin
				power_down_flag <= 1'b1;
			end else if (wdt_clear_cmd) begin
				power_down_flag <= 1'b0;
			end
			if (wdt_timeout) begin
				timeout_flag <= 1'b1;
			end else if (halt_enter) begin
				timeout_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Oscillator drive
	opm_osc_s next_osc;
	logic     high_kept;
	logic     low_kept;

	assign high_kept = (next_mode == opm_run) || (next_mode == opm_idle_both) || (next_mode == opm_idle_high);
	assign low_kept  = (next_mode == opm_run) || (next_mode == opm_idle_both) || (next_mode == opm_idle_low);

	always_comb begin
		next_osc                = '0;
		next_osc.high_speed_internal_rc_en        = internal_rc_enable && high_kept;
		next_osc.high_speed_internal_rc_trim      = high_speed_internal_rc_norm(internal_rc_freq_select);
		next_osc.hxt_en         = high_crystal_enable && high_kept;
		next_osc.hxt_high_drive = crystal_drive_mode;
		next_osc.lxt_en         = low_crystal_enable && low_kept;
		next_osc.lxt_speedup    = low_crystal_speedup;
		// Low RC runs in every mode from the first clock after reset: it clocks the watchdog
		next_osc.low_speed_internal_rc_en        = 1'b1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_ctrl <= '0;
		end else begin
			osc_ctrl <= next_osc;
		end
	end

	////////////////////////////////////////////////////////////
	// Settle counters
	logic [2:0]  osc_on;
	logic [2:0]  osc_on_q;
	logic [1:0]  trim_q;
	logic [2:0]  osc_restart;
	logic [11:0] settle_target [3];
	logic [11:0] settle_cnt [3];

	assign osc_on = {osc_ctrl.lxt_en, osc_ctrl.hxt_en, osc_ctrl.high_speed_internal_rc_en};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_on_q <= 3'h0;
			trim_q   <= OPM_HIGH_SPEED_INTERNAL_RC_2M;
		end else begin
			osc_on_q <= osc_on;
			trim_q   <= osc_ctrl.high_speed_internal_rc_trim;
		end
	end

	// A retune counts as a restart: the RC re-settles at its new rate
	always_comb begin
		osc_restart           = osc_on & ~osc_on_q;
		osc_restart[OPM_HIGH_SPEED_INTERNAL_RC] = osc_restart[OPM_HIGH_SPEED_INTERNAL_RC] | (osc_ctrl.high_speed_internal_rc_trim != trim_q);
		settle_target[OPM_HIGH_SPEED_INTERNAL_RC] = OPM_HIGH_SPEED_INTERNAL_RC_SET_CYC;
		settle_target[OPM_HXT]  = OPM_HXT_SET_CYC;
		settle_target[OPM_LXT]  = osc_ctrl.lxt_speedup ? OPM_LXT_FAST_CYC : OPM_LXT_SLOW_CYC;
	end

	for (genvar g = 0; g < 3; g++) begin : g_settle
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				settle_cnt[g] <= 12'h000;
				stable[g]     <= 1'b0;
			end else if (!osc_on[g] || osc_restart[g]) begin
				settle_cnt[g] <= 12'h000;
				stable[g]     <= 1'b0;
			end else if (!stable[g]) begin
				settle_cnt[g] <= settle_cnt[g] + 12'h001;
				if (settle_cnt[g] == settle_target[g] - 12'h001) begin
					stable[g] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			high_speed_internal_rc_freq_active <= OPM_HIGH_SPEED_INTERNAL_RC_2M;
		end else if (stable[OPM_HIGH_SPEED_INTERNAL_RC] && !osc_restart[OPM_HIGH_SPEED_INTERNAL_RC]) begin
			high_speed_internal_rc_freq_active <= osc_ctrl.high_speed_internal_rc_trim;
		end
	end

	////////////////////////////////////////////////////////////
	// System clock selection
	logic req_low;
	logic high_ok;
	logic low_ok;

	assign req_low = system_clock_source_field == OPM_CKS_LOW;
	assign high_ok = high_clock_select ? stable[OPM_HXT] : stable[OPM_HIGH_SPEED_INTERNAL_RC];
	assign low_ok  = low_clock_select ? stable[OPM_LXT] : 1'b1;

	// Old selection stays until the target oscillator is stable
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clk_sel <= '0;
		end else if (req_low ? low_ok : high_ok) begin
			clk_sel.low_speed <= req_low;
			clk_sel.div_code  <= system_clock_source_field;
			clk_sel.high_xtal <= high_clock_select;
			clk_sel.low_xtal  <= low_clock_select;
		end
	end

	////////////////////////////////////////////////////////////
	// Register read
	logic [7:0] read_mux;

	always_comb begin
		read_mux = 8'h00;
		case (addr)
			OPM_ADDR_IRC: begin
				read_mux[OPM_EN_BIT]        = internal_rc_enable;
				read_mux[OPM_FLAG_BIT]      = stable[OPM_HIGH_SPEED_INTERNAL_RC];
				read_mux[OPM_FREQ_LSB +: 2] = internal_rc_freq_select;
			end
			OPM_ADDR_HXC: begin
				read_mux[OPM_EN_BIT]   = high_crystal_enable;
				read_mux[OPM_FLAG_BIT] = stable[OPM_HXT];
				read_mux[OPM_OPT_BIT]  = crystal_drive_mode;
			end
			OPM_ADDR_LXC: begin
				read_mux[OPM_EN_BIT]   = low_crystal_enable;
				read_mux[OPM_FLAG_BIT] = stable[OPM_LXT];
				read_mux[OPM_OPT_BIT]  = low_crystal_speedup;
			end
			OPM_ADDR_SCC: begin
				read_mux[OPM_CKS_LSB +: 3]  = system_clock_source_field;
				read_mux[OPM_FHS_BIT]       = high_clock_select;
				read_mux[OPM_FSS_BIT]       = low_clock_select;
				read_mux[OPM_KEEP_HI_BIT]   = halt_keep_high_osc;
				read_mux[OPM_KEEP_LO_BIT]   = halt_keep_low_osc;
			end
			OPM_ADDR_STAT: begin
				read_mux[OPM_ST_PDF_BIT]  = power_down_flag;
				read_mux[OPM_ST_TO_BIT]   = timeout_flag;
				read_mux[OPM_ST_HALT_BIT] = cpu_hold;
				read_mux[OPM_ST_SLOW_BIT] = clk_sel.low_speed;
			end
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd_stb ? read_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence halt_sleep_s;
		halt_enter && !halt_keep_high_osc && !halt_keep_low_osc && !wdt_timeout;
	endsequence

	sequence sleep_state_s;
		cpu_hold && !sys_clk_run && power_down_flag && wdt_clear && !timeout_flag[*1];
	endsequence

	high_speed_internal_rc_map_a: assert property (high_speed_internal_rc_freq_active != OPM_HIGH_SPEED_INTERNAL_RC_ALIAS)
		else $error("high RC active frequency holds alias code");
	high_speed_internal_rc_apply_a: assert property ($changed(high_speed_internal_rc_freq_active) |-> $past(stable[OPM_HIGH_SPEED_INTERNAL_RC]) && high_speed_internal_rc_freq_active == $past(osc_ctrl.high_speed_internal_rc_trim, 2))
		else $error("RC frequency applied before stable");
	high_speed_internal_rc_restart_a: assert property ($rose(osc_ctrl.high_speed_internal_rc_en) |-> !stable[OPM_HIGH_SPEED_INTERNAL_RC] ##1 !stable[OPM_HIGH_SPEED_INTERNAL_RC])
		else $error("RC stable flag not cleared on enable");
	high_speed_internal_rc_off_a: assert property (!internal_rc_enable |=> !osc_ctrl.high_speed_internal_rc_en ##1 !stable[OPM_HIGH_SPEED_INTERNAL_RC])
		else $error("RC runs while disabled");
	drive_lock_a: assert property (wr_stb && addr == OPM_ADDR_HXC && drive_locked |=> $stable(crystal_drive_mode))
		else $error("crystal drive mode changed while locked");
	speedup_lock_a: assert property (wr_stb && addr == OPM_ADDR_LXC && speedup_locked |=> $stable(low_crystal_speedup))
		else $error("speed-up changed while low crystal selected");
	slow_switch_a: assert property ($rose(clk_sel.low_speed) |-> $past(low_ok))
		else $error("slow switch before low clock stable");
	fast_switch_a: assert property ($fell(clk_sel.low_speed) |-> $past(high_ok))
		else $error("fast switch before high clock stable");
	sleep_entry_a: assert property (halt_sleep_s |=> sleep_state_s ##1 !wdt_clear)
		else $error("sleep entry effects wrong");
	sleep_osc_a: assert property (halt_sleep_s |=> !osc_ctrl.high_speed_internal_rc_en && !osc_ctrl.hxt_en && !osc_ctrl.lxt_en)
		else $error("oscillator left running in sleep");
	idle_decode_a: assert property (halt_enter && !halt_keep_high_osc && halt_keep_low_osc |=> mode == opm_idle_low)
		else $error("idle decode wrong");
	unimpl_zero_a: assert property (rd_stb && addr == OPM_ADDR_IRC |=> rdata[7:4] == 4'h0)
		else $error("unimplemented bits read non-zero");

endmodule

/* File: opm_cpu_model.sv */
// CPU core stand-in that issues halt, wake and watchdog event pulses.
// Assumes the caller is on clk; every event lasts exactly one cycle.
`timescale 1ns/1ps

module opm_cpu_model (
	// Clock
	input  wire logic clk,
	// Core events
	output logic      halt_req,
	output logic      wake_req,
	output logic      wdt_clear_cmd,
	output logic      wdt_timeout
);
	initial begin
		{halt_req, wake_req, wdt_clear_cmd, wdt_timeout} = 4'h0;
	end

	////////////////////////////////////////////////////////////
	// Bits: halt, wake, watchdog clear, time-out; returns at taking edge
	task automatic pulse(input logic [3:0] ev);
		@(posedge clk);
		{halt_req, wake_req, wdt_clear_cmd, wdt_timeout} <= ev;
		@(posedge clk);
		{halt_req, wake_req, wdt_clear_cmd, wdt_timeout} <= 4'h0;
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the oscillator and power mode controller.
// Assumes one 100 MHz clock; reads are scored by a queue watcher.
`timescale 1ns/1ps

module tb_top;
	import opm_pkg::*;

	logic                 clk;
	logic                 reset;
	logic [2:0]           addr;
	logic [7:0]           wdata;
	logic                 wr_stb;
	logic                 rd_stb;
	logic [7:0]           rdata;
	logic                 halt_req;
	logic                 wake_req;
	logic                 wdt_clear_cmd;
	logic                 wdt_timeout;
	logic                 crystal_pins_on;
	opm_osc_s             osc_ctrl;
	opm_clk_sel_s         clk_sel;
	logic [1:0]           high_speed_internal_rc_freq_active;
	logic                 cpu_hold;
	logic                 sys_clk_run;
	logic                 wdt_clear;
	logic                 power_down_flag;
	logic                 timeout_flag;
	logic [7:0]           exp_q[$];
	logic                 rd_seen = 1'b0;
	logic [1:0]           prev;
	logic [7:0]           r;
	logic [1:0]           seq [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
	int                   err_total;
	int                   checks_done;
	int                   seed = 28410;

	opm_ctrl i_dut (
		.clk              (clk),
		.reset            (reset),
		.addr             (addr),
		.wdata            (wdata),
		.wr_stb           (wr_stb),
		.rd_stb           (rd_stb),
		.rdata            (rdata),
		.halt_req         (halt_req),
		.wake_req         (wake_req),
		.wdt_clear_cmd    (wdt_clear_cmd),
		.wdt_timeout      (wdt_timeout),
		.crystal_pins_on  (crystal_pins_on),
		.osc_ctrl         (osc_ctrl),
		.clk_sel          (clk_sel),
		.high_speed_internal_rc_freq_active (high_speed_internal_rc_freq_active),
		.cpu_hold         (cpu_hold),
		.sys_clk_run      (sys_clk_run),
		.wdt_clear        (wdt_clear),
		.power_down_flag  (power_down_flag),
		.timeout_flag     (timeout_flag)
	);

	opm_cpu_model i_cpu (
		.clk              (clk),
		.halt_req         (halt_req),
		.wake_req         (wake_req),
		.wdt_clear_cmd    (wdt_clear_cmd),
		.wdt_timeout      (wdt_timeout)
	);

	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	// Expected value noted when the read is issued
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) begin
			check(rdata, exp_q.pop_front());
		end
		rd_seen <= rd_stb;
	end

	// Whole run is some 4000 cycles; a hang is cut at 20000
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		{addr, wdata, wr_stb, rd_stb, crystal_pins_on} = '0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// Reset values and unmapped places
		rd(OPM_ADDR_IRC, 8'h01);
		rd(OPM_ADDR_HXC, 8'h00);
		rd(OPM_ADDR_LXC, 8'h00);
		rd(OPM_ADDR_SCC, 8'h00);
		for (int i = 5; i < 8; i++) begin
			wr(3'(i), 8'($random(seed)));
			rd(3'(i), 8'h00);
		end
		repeat (200) @(posedge clk);
		rd(OPM_ADDR_IRC, 8'h03);
		// RC retune: old frequency holds until the flag returns
		prev = 2'h0;
		foreach (seq[k]) begin
			r = 8'($random(seed));
			wr(OPM_ADDR_IRC, {r[7:4], seq[k], 2'h1});
			repeat (3) @(posedge clk);
			rd(OPM_ADDR_IRC, {4'h0, seq[k], 2'h1});
			check({6'h0, high_speed_internal_rc_freq_active}, {6'h0, prev});
			prev = (seq[k] == 2'h3) ? 2'h0 : seq[k];
			check({6'h0, osc_ctrl.high_speed_internal_rc_trim}, {6'h0, prev});
			repeat (200) @(posedge clk);
			check({6'h0, high_speed_internal_rc_freq_active}, {6'h0, prev});
			rd(OPM_ADDR_IRC, {4'h0, seq[k], 2'h3});
		end
		// RC off and on again: flag drops, then restarts from zero
		wr(OPM_ADDR_IRC, 8'h00);
		repeat (3) @(posedge clk);
		rd(OPM_ADDR_IRC, 8'h00);
		check({7'h0, osc_ctrl.high_speed_internal_rc_en}, 8'h00);
		wr(OPM_ADDR_IRC, 8'h01);
		repeat (3) @(posedge clk);
		rd(OPM_ADDR_IRC, 8'h01);
		// Crystal: mode set before enable, then locked
		crystal_pins_on <= 1'b1;
		wr(OPM_ADDR_HXC, 8'h04);
		wr(OPM_ADDR_HXC, 8'h05);
		repeat (3) @(posedge clk);
		rd(OPM_ADDR_HXC, 8'h05);
		wr(OPM_ADDR_HXC, 8'h01);
		repeat (350) @(negedge clk);
		check({6'h0, osc_ctrl.hxt_en, osc_ctrl.hxt_high_drive}, 8'h03);
		rd(OPM_ADDR_HXC, 8'h07);
		crystal_pins_on <= 1'b0;
		wr(OPM_ADDR_HXC, 8'h01);
		rd(OPM_ADDR_HXC, 8'h03);
		// Every divider code from the crystal
		for (int i = 0; i < 7; i++) begin
			wr(OPM_ADDR_SCC, {3'(i), 5'h08});
			repeat (3) @(negedge clk);
			check({2'h0, clk_sel}, {3'h0, 3'(i), 2'h2});
		end
		// Slow mode waits for the low crystal
		wr(OPM_ADDR_LXC, 8'h05);
		wr(OPM_ADDR_SCC, 8'hE4);
		wr(OPM_ADDR_LXC, 8'h01);
		@(negedge clk);
		check({2'h0, clk_sel}, 8'h1A);
		check({7'h0, osc_ctrl.lxt_speedup}, 8'h01);
		repeat (830) @(negedge clk);
		check({2'h0, clk_sel}, 8'h3D);
		rd(OPM_ADDR_LXC, 8'h07);
		rd(OPM_ADDR_STAT, 8'h08);
		wr(OPM_ADDR_SCC, 8'hE0);
		repeat (3) @(negedge clk);
		check({2'h0, clk_sel}, 8'h3C);
		// Every halt mode, with a pending time-out flag cleared on entry
		for (int i = 0; i < 4; i++) begin
			wr(OPM_ADDR_SCC, {6'h02, 2'(i)});
			i_cpu.pulse(4'h3);
			rd(OPM_ADDR_STAT, 8'h02);
			i_cpu.pulse(4'h8);
			@(negedge clk);
			check({3'h0, cpu_hold, sys_clk_run, wdt_clear, power_down_flag, timeout_flag}, 8'h16);
			check({4'h0, osc_ctrl.low_speed_internal_rc_en, osc_ctrl.high_speed_internal_rc_en, osc_ctrl.hxt_en, osc_ctrl.lxt_en},
				{4'h0, 1'b1, i[1], i[1], i[0]});
			rd(OPM_ADDR_STAT, 8'h05);
			i_cpu.pulse(4'h4);
			@(negedge clk);
			check({6'h0, cpu_hold, sys_clk_run}, 8'h01);
			repeat (400) @(posedge clk);
		end
		print_verdict();
	end
endmodule
